/* File: rtl/rfs_params.svh */
// constants for the ramped keying sweep engine
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH
`define RFS_ADDR_STEP0      8'h10
`define RFS_ADDR_STEP5      8'h15
`define RFS_ADDR_LOW0       8'h04
`define RFS_ADDR_HIGH0      8'h0a
`define RFS_ADDR_RATE0      8'h1a
`define RFS_ADDR_RATE2      8'h1c
`define RFS_ADDR_CTRL       8'h1f
`define RFS_ADDR_UPD0       8'h16
`define RFS_ADDR_UPD3       8'h19
`define RFS_ADDR_MODE       8'h1e
`define RFS_BIT_TRIANGLE    5
`define RFS_BIT_CLR_FREQ    3
`define RFS_BIT_CLR_ALL     2
`define RFS_BIT_INT_UPDATE  0
`define RFS_CTRL_RESET      8'h01
`define RFS_MODE_RESET      3'h0
`define RFS_MODE_RAMPED     3'h2
`define RFS_MODE_CHIRP      3'h3
`define RFS_RATE_RESET      20'h00001
`define RFS_UPD_RESET       32'h00000040
`endif

/* File: rtl/rfs_pkg.sv */
// types for the ramped keying sweep engine
package rfs_pkg;
    typedef enum logic [2:0] {
        RFS_IDLE = 3'b001,
        RFS_RAMP = 3'b010,
        RFS_HOLD = 3'b100
    } rfs_state_t;
endpackage

/* File: rtl/rfs_rate_counter.sv */
// ramp-rate down-counter giving one pulse every n+1 clocks
`timescale 1ns/1ps
module rfs_rate_counter (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        run,
    input  wire logic        restart,
    input  wire logic [19:0] rate,
    output logic             tick
);
    typedef struct packed {
        logic [19:0] count;
        logic        tick;
    } rfs_rc_t;

    rfs_rc_t r;
    rfs_rc_t next_r;

    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (restart || !run) begin
            next_r.count = rate;
        end else if (r.count == 20'h00000) begin
            next_r.tick  = 1'b1;
            next_r.count = rate;
        end else begin
            next_r.count = r.count - 20'h00001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;

    period_exact_a: assert property (@(posedge clk_sys) disable iff (reset)
        (r.tick && run && !restart && rate == 20'h00003 && $stable(rate))[*1] ##1
        (run && !restart && rate == 20'h00003)[*3]
        |-> ##1 r.tick)
        else $error("ramp pulse spacing wrong");
endmodule

/* File: rtl/rfs_sweep_engine.sv */
// ramped keying frequency sweep engine with byte register port
`timescale 1ns/1ps
`include "rfs_params.svh"
// =====================================================================
// Summary of operation
// - rate pulse every N+1 clocks
// - each rate pulse steps frequency accumulator
// - counter stops at destination word
// - destination held while select unchanged
// - 48-bit unsigned step word at 10-15h
// - step added to accumulator each pulse
// - accumulator added/subtracted from start word
// - early select toggle reverses ramp immediately
// - triangle bit sweeps, ignores select pin
// - triangle runs continuously, equal dwell
// - triangle start chosen by select level
// - new step acts immediately; new rate from next reload
// - 32-bit internal update counter pulses
// - frequency clear is one-clock pulse
// - held clear pulses on each update edge
// - clear pulse restarts ramp from start
// - clear-all clears both accumulators
// - clear-all held keeps 0 Hz output
// - ramped mode confined; chirp unbounded
// - select low low word, high high word
// - select change starts rate counter
module rfs_sweep_engine (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic        update_pin,
    input  wire logic        keying_select_pin,
    output logic      [7:0]  reg_rdata,
    output logic      [47:0] tuning_word,
    output logic      [47:0] phase_accumulator,
    output logic             update_pulse,
    output logic             ramp_busy
);
    // =================================================================
    // state
    typedef struct packed {
        logic [47:0]         sweep_step_word;
        logic [47:0]         tuning_word_low;
        logic [47:0]         tuning_word_high;
        logic [19:0]         rate;
        logic [31:0]         upd_period;
        logic [7:0]          sweep_control;
        logic [2:0]          mode;
        logic [7:0]          rdata;
        logic [47:0]         frequency_accumulator;
        logic [47:0]         phase_accumulator;
        logic [47:0]         tuning_word;
        logic [31:0]         upd_count;
        logic                upd_pulse;
        logic [2:0]          upd_sync;
        logic [1:0]          sel_sync;
        logic                sel_prev;
        logic                dir;
        logic                tri_prev;
        logic                clr_pend;
        rfs_pkg::rfs_state_t state;
    } rfs_reg_t;

    rfs_reg_t r;
    rfs_reg_t next_r;
    logic     tick;
    logic     run;
    logic     restart;

    rfs_rate_counter u_rate (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (run),
        .restart (restart),
        .rate    (r.rate),
        .tick    (tick)
    );

    // =================================================================
    // next state
    logic        sel;
    logic        triangle;
    logic        ramped;
    logic        upd_edge;
    logic        sel_edge;
    logic        clr_pulse;
    logic        clr_all;
    logic [47:0] start_word;
    logic [47:0] dest_word;
    logic [47:0] next_acc;
    logic [47:0] span;
    logic [48:0] next_word;
    logic        reached;

    assign run     = (r.state == rfs_pkg::RFS_RAMP) && !clr_all;
    assign restart = sel_edge || clr_pulse || (triangle && !r.tri_prev);

    always_comb begin
        next_r    = r;
        sel       = r.sel_sync[1];
        triangle  = r.sweep_control[`RFS_BIT_TRIANGLE] && r.mode == `RFS_MODE_RAMPED;
        ramped    = r.mode == `RFS_MODE_RAMPED;
        clr_all   = r.sweep_control[`RFS_BIT_CLR_ALL];
        upd_edge  = r.upd_sync[1] && !r.upd_sync[2];
        if (r.sweep_control[`RFS_BIT_INT_UPDATE]) begin
            upd_edge = r.upd_pulse;
        end
        sel_edge  = !triangle && (sel != r.sel_prev);
        clr_pulse = r.clr_pend || (r.sweep_control[`RFS_BIT_CLR_FREQ] && upd_edge);
        // dir 0: ramping toward high word from low (start low)
        start_word = r.dir ? r.tuning_word_high : r.tuning_word_low;
        dest_word  = r.dir ? r.tuning_word_low : r.tuning_word_high;
        span       = r.tuning_word_high - r.tuning_word_low;
        next_acc   = r.frequency_accumulator + r.sweep_step_word;
        reached    = ramped && (next_acc >= span);
        // registers
        next_r.sel_sync = {r.sel_sync[0], keying_select_pin};
        next_r.upd_sync = {r.upd_sync[1:0], update_pin};
        next_r.sel_prev = sel;
        next_r.tri_prev = triangle;
        next_r.clr_pend = 1'b0;
        next_r.rdata    = 8'h00;
        if (reg_write) begin
            if (reg_addr >= `RFS_ADDR_STEP0 && reg_addr <= `RFS_ADDR_STEP5) begin
                next_r.sweep_step_word[8*(reg_addr-`RFS_ADDR_STEP0) +: 8] = reg_wdata;
            end else if (reg_addr >= `RFS_ADDR_LOW0 && reg_addr < `RFS_ADDR_HIGH0) begin
                next_r.tuning_word_low[8*(reg_addr-`RFS_ADDR_LOW0) +: 8] = reg_wdata;
            end else if (reg_addr >= `RFS_ADDR_HIGH0 && reg_addr < `RFS_ADDR_STEP0) begin
                next_r.tuning_word_high[8*(reg_addr-`RFS_ADDR_HIGH0) +: 8] = reg_wdata;
            end else if (reg_addr == `RFS_ADDR_RATE2) begin
                // only the low nibble of the top byte exists in a 20-bit rate
                next_r.rate[19:16] = reg_wdata[3:0];
            end else if (reg_addr >= `RFS_ADDR_RATE0 && reg_addr < `RFS_ADDR_RATE2) begin
                next_r.rate[8*(reg_addr-`RFS_ADDR_RATE0) +: 8] = reg_wdata;
            end else if (reg_addr >= `RFS_ADDR_UPD0 && reg_addr <= `RFS_ADDR_UPD3) begin
                next_r.upd_period[8*(reg_addr-`RFS_ADDR_UPD0) +: 8] = reg_wdata;
            end else if (reg_addr == `RFS_ADDR_MODE) begin
                next_r.mode = reg_wdata[2:0];
            end else if (reg_addr == `RFS_ADDR_CTRL) begin
                next_r.sweep_control = reg_wdata;
                // rising write of the clear bit fires one pulse at once
                if (reg_wdata[`RFS_BIT_CLR_FREQ]
                        && !r.sweep_control[`RFS_BIT_CLR_FREQ]) begin
                    next_r.clr_pend = 1'b1;
                end
            end
        end
        if (reg_read) begin
            if (reg_addr >= `RFS_ADDR_STEP0 && reg_addr <= `RFS_ADDR_STEP5) begin
                next_r.rdata = r.sweep_step_word[8*(reg_addr-`RFS_ADDR_STEP0) +: 8];
            end else if (reg_addr >= `RFS_ADDR_LOW0 && reg_addr < `RFS_ADDR_HIGH0) begin
                next_r.rdata = r.tuning_word_low[8*(reg_addr-`RFS_ADDR_LOW0) +: 8];
            end else if (reg_addr >= `RFS_ADDR_HIGH0 && reg_addr < `RFS_ADDR_STEP0) begin
                next_r.rdata = r.tuning_word_high[8*(reg_addr-`RFS_ADDR_HIGH0) +: 8];
            end else if (reg_addr >= `RFS_ADDR_RATE0 && reg_addr <= `RFS_ADDR_RATE2) begin
                next_r.rdata = 8'(r.rate >> (8*(reg_addr-`RFS_ADDR_RATE0)));
            end else if (reg_addr >= `RFS_ADDR_UPD0 && reg_addr <= `RFS_ADDR_UPD3) begin
                next_r.rdata = r.upd_period[8*(reg_addr-`RFS_ADDR_UPD0) +: 8];
            end else if (reg_addr == `RFS_ADDR_MODE) begin
                next_r.rdata = {4'h0, r.state == rfs_pkg::RFS_RAMP, r.mode};
            end else if (reg_addr == `RFS_ADDR_CTRL) begin
                next_r.rdata = r.sweep_control;
            end
        end
        // internal update counter
        next_r.upd_pulse = 1'b0;
        if (r.upd_count == 32'h00000000) begin
            next_r.upd_pulse = 1'b1;
            next_r.upd_count = r.upd_period;
        end else begin
            next_r.upd_count = r.upd_count - 32'h00000001;
        end
        // sweep control
        if (triangle && !r.tri_prev) begin
            next_r.dir                   = sel;
            next_r.frequency_accumulator = 48'h000000000000;
            next_r.state                 = rfs_pkg::RFS_RAMP;
        end else if (sel_edge) begin
            // early toggle turns round from where the ramp stands
            // select high heads for the high word, so the ramp starts low
            next_r.dir                   = !sel;
            next_r.frequency_accumulator = (r.state == rfs_pkg::RFS_RAMP && ramped)
                                           ? span - r.frequency_accumulator : 48'h0;
            next_r.state                 = rfs_pkg::RFS_RAMP;
        end else if (clr_pulse) begin
            next_r.frequency_accumulator = 48'h000000000000;
            // an idle engine has no ramp to restart; the start-up
            // clear toggle must not launch a sweep on its own
            if (r.state != rfs_pkg::RFS_IDLE) begin
                next_r.state = rfs_pkg::RFS_RAMP;
            end
        end else if (tick && r.state == rfs_pkg::RFS_RAMP) begin
            if (reached) begin
                next_r.frequency_accumulator = span;
                if (triangle) begin
                    // endpoints dwell one period like any step
                    next_r.dir                   = !r.dir;
                    next_r.frequency_accumulator = 48'h000000000000;
                end else begin
                    next_r.state = rfs_pkg::RFS_HOLD;
                end
            end else begin
                next_r.frequency_accumulator = next_acc;
            end
        end
        if (clr_all) begin
            next_r.frequency_accumulator = 48'h000000000000;
        end
        case (r.state)
            rfs_pkg::RFS_IDLE: next_r.state = next_r.state;
            rfs_pkg::RFS_RAMP: next_r.state = next_r.state;
            rfs_pkg::RFS_HOLD: next_r.state = next_r.state;
            default:           next_r.state = rfs_pkg::RFS_IDLE;
        endcase
        // output word: ramped mode bounded, chirp free
        if (ramped && r.dir) begin
            next_word = {1'b0, start_word} - {1'b0, r.frequency_accumulator};
        end else begin
            next_word = {1'b0, start_word} + {1'b0, r.frequency_accumulator};
        end
        next_r.tuning_word = next_word[47:0];
        if (clr_all) begin
            next_r.tuning_word       = 48'h000000000000;
            next_r.phase_accumulator = 48'h000000000000;
        end else begin
            next_r.phase_accumulator = r.phase_accumulator + r.tuning_word;
        end
        if (dest_word == start_word) begin
            next_r.tuning_word = next_r.tuning_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r               <= '0;
            r.sweep_control <= `RFS_CTRL_RESET;
            r.mode          <= `RFS_MODE_RESET;
            r.rate          <= `RFS_RATE_RESET;
            r.upd_period    <= `RFS_UPD_RESET;
            r.state         <= rfs_pkg::RFS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata         = r.rdata;
    assign tuning_word       = r.tuning_word;
    assign phase_accumulator = r.phase_accumulator;
    assign update_pulse      = r.upd_pulse;
    // one-hot: the ramp state bit is itself a flop
    assign ramp_busy         = r.state[1];

    // =================================================================
    // checks
    hold_no_move_a: assert property (@(posedge clk_sys) disable iff (reset)
        (r.state == rfs_pkg::RFS_HOLD && !restart && !clr_all)
        |=> $stable(r.frequency_accumulator))
        else $error("held sweep moved");
    clamp_dest_a: assert property (@(posedge clk_sys) disable iff (reset)
        (tick && reached && !triangle && !restart && !clr_all
         && r.state == rfs_pkg::RFS_RAMP)
        |=> r.frequency_accumulator == $past(span) && r.state == rfs_pkg::RFS_HOLD)
        else $error("destination not clamped");
    step_add_a: assert property (@(posedge clk_sys) disable iff (reset)
        (tick && !reached && !restart && !clr_all && r.state == rfs_pkg::RFS_RAMP)
        |=> r.frequency_accumulator == $past(next_acc))
        else $error("step not accumulated");
    clear_all_a: assert property (@(posedge clk_sys) disable iff (reset)
        clr_all |=> r.frequency_accumulator == 48'h0 && r.tuning_word == 48'h0)
        else $error("clear-all not holding zero");
    freq_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (clr_pulse && !clr_all && !sel_edge && !(triangle && !r.tri_prev)
         && r.state != rfs_pkg::RFS_IDLE)
        |=> r.frequency_accumulator == 48'h0 && r.state == rfs_pkg::RFS_RAMP)
        else $error("clear pulse did not restart");
    upd_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (r.sweep_control[`RFS_BIT_CLR_FREQ] && upd_edge) |-> clr_pulse)
        else $error("update edge gave no clear");
    tri_start_a: assert property (@(posedge clk_sys) disable iff (reset)
        (triangle && !r.tri_prev) |=> r.dir == $past(sel))
        else $error("triangle start wrong");
    // in triangle only an endpoint may turn the sweep, never the pin
    tri_ignore_a: assert property (@(posedge clk_sys) disable iff (reset)
        (triangle && r.tri_prev && !tick) |=> r.dir == $past(r.dir))
        else $error("select pin acted in triangle");
    clear_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_write && reg_addr == `RFS_ADDR_CTRL && reg_wdata[`RFS_BIT_CLR_FREQ]
         && !r.sweep_control[`RFS_BIT_CLR_FREQ]) |=> clr_pulse)
        else $error("clear write gave no pulse");
    phase_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        clr_all |=> r.phase_accumulator == 48'h0)
        else $error("phase accumulator not cleared");
    select_start_a: assert property (@(posedge clk_sys) disable iff (reset)
        (sel_edge && !clr_all) |=> r.state == rfs_pkg::RFS_RAMP)
        else $error("select change did not start ramp");
endmodule

/* File: tb/rfs_host_pins.sv */
// host-side pin model: keying level source and external update clock
`timescale 1ns/1ps
module rfs_host_pins (
    input  wire logic clk_sys,
    input  wire logic level_req,
    input  wire logic upd_req,
    output logic      keying_select_pin,
    output logic      update_pin
);
    // ==============================
    // pin drive
    // levels move just after the edge and stand until asked otherwise
    initial begin
        keying_select_pin = 1'b0;
        update_pin = 1'b0;
    end
    always @(posedge clk_sys) begin
        keying_select_pin <= #1 level_req;
        update_pin <= #1 upd_req;
    end
endmodule

/* File: tb/rfs_sweep_engine_test.sv */
// self-checking bench for the ramped keying sweep engine
`timescale 1ns/1ps
module rfs_sweep_engine_test;
    logic        clk_sys, reset, reg_write, reg_read, update_pin, keying_select_pin;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [47:0] tuning_word, phase_accumulator, prev_tw, chg_delta, low_w, high_w, step_w;
    logic        update_pulse, ramp_busy, level_req, upd_req, rd_pend, found;
    int          errors, cmp_count, cyc, chg_cyc, chg_gap, upd_cyc, upd_gap, seed;
    logic [7:0]  rd_q[$];

    // ==============================
    // clock, design and pins
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    rfs_sweep_engine i_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .update_pin(update_pin), .keying_select_pin(keying_select_pin),
        .reg_rdata(reg_rdata), .tuning_word(tuning_word),
        .phase_accumulator(phase_accumulator), .update_pulse(update_pulse),
        .ramp_busy(ramp_busy));
    rfs_host_pins i_pins (.clk_sys(clk_sys), .level_req(level_req), .upd_req(upd_req),
        .keying_select_pin(keying_select_pin), .update_pin(update_pin));

    // ==============================
    // helpers
    task automatic check(input logic [47:0] seen, input logic [47:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_write = 1'b0;
    endtask
    // little-endian byte stream, lowest address first
    task automatic wr_w(input logic [7:0] a, input logic [47:0] v, input int n);
        for (int i = 0; i < n; i++) wr(a + 8'(i), v[8*i +: 8]);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] expv);
        rd_q.push_back(expv);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_read = 1'b0;
    endtask
    task automatic wait_chg();
        int c0;
        c0 = chg_cyc;
        repeat (2000) begin
            @(posedge clk_sys);
            #2;
            if (chg_cyc != c0) return;
        end
    endtask
    task automatic wait_tw(input logic [47:0] t, input int n);
        found = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #2;
            if (tuning_word === t) begin
                found = 1'b1;
                return;
            end
        end
    endtask
    task automatic wait_upd();
        repeat (40) begin
            @(posedge clk_sys);
            #2;
            if (update_pulse === 1'b1) return;
        end
    endtask

    // ==============================
    // output watcher: read answers and frequency steps
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            errors++;
            results();
        end
        if (rd_pend && rd_q.size() > 0) check(reg_rdata, rd_q.pop_front());
        rd_pend <= reg_read;
        if (tuning_word !== prev_tw) begin
            chg_gap <= cyc - chg_cyc;
            chg_cyc <= cyc;
            chg_delta <= tuning_word - prev_tw;
        end
        prev_tw <= tuning_word;
        if (update_pulse === 1'b1) begin
            upd_gap <= cyc - upd_cyc;
            upd_cyc <= cyc;
        end
    end

    // ==============================
    // main sequence
    initial begin
        {reg_write, reg_read, upd_req, level_req, rd_pend} = '0;
        {reg_addr, reg_wdata, prev_tw, chg_delta} = '0;
        {errors, cmp_count, cyc, chg_cyc, chg_gap, upd_cyc, upd_gap} = '0;
        seed = 32'h6459;
        reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        rd(8'h1f, 8'h01);
        rd(8'h1e, 8'h00);
        rd(8'h1a, 8'h01);
        rd(8'h16, 8'h40);
        rd(8'h30, 8'h00);
        // span kept off a step multiple so the last step must clamp
        step_w = 48'h100 | (48'($random(seed)) & 48'hff);
        low_w = 48'h0000_0010_0000;
        high_w = low_w + 48'h2345;
        wr_w(8'h04, low_w, 6);
        wr_w(8'h0a, high_w, 6);
        wr_w(8'h10, step_w, 6);
        for (int i = 0; i < 6; i++) rd(8'h10 + 8'(i), step_w[8*i +: 8]);
        wr_w(8'h1a, 48'h3, 3);
        wr(8'h1e, 8'h02);
        wr(8'h1f, 8'h09);
        wr(8'h1f, 8'h01);
        level_req = 1'b1;
        repeat (3) wait_chg();
        check(48'(chg_gap), 48'h4);
        check(chg_delta, step_w);
        wr_w(8'h1a, 48'h5, 3);
        repeat (2) wait_chg();
        check(48'(chg_gap), 48'h6);
        wait_tw(high_w, 2000);
        check(48'(found), 48'h1);
        repeat (3) @(posedge clk_sys);
        check(48'(ramp_busy), 48'h0);
        repeat (40) @(posedge clk_sys);
        check(tuning_word, high_w);
        level_req = 1'b0;
        repeat (3) wait_chg();
        check(chg_delta, 48'h0 - step_w);
        level_req = 1'b1;
        repeat (3) wait_chg();
        check(chg_delta, step_w);
        level_req = 1'b0;
        wait_tw(low_w, 2000);
        check(48'(found), 48'h1);
        rd(8'h1e, 8'h02);
        wr(8'h16, 8'h10);
        repeat (100) @(posedge clk_sys);
        check(48'(upd_gap), 48'h11);
        wr(8'h1f, 8'h09);
        wait_tw(high_w, 6);
        check(48'(found), 48'h1);
        wait_upd();
        repeat (10) @(posedge clk_sys);
        check(48'(tuning_word !== high_w), 48'h1);
        wait_upd();
        wait_tw(high_w, 6);
        check(48'(found), 48'h1);
        // external update clock: clear held, restart on the pin's rising edge
        wr(8'h1f, 8'h08);
        repeat (10) @(posedge clk_sys);
        check(48'(tuning_word !== high_w), 48'h1);
        #1;
        upd_req = 1'b1;
        wait_tw(high_w, 8);
        check(48'(found), 48'h1);
        upd_req = 1'b0;
        wr(8'h1f, 8'h05);
        repeat (4) @(posedge clk_sys);
        check(phase_accumulator, 48'h0);
        repeat (10) @(posedge clk_sys);
        check(phase_accumulator, 48'h0);
        wr(8'h1f, 8'h01);
        repeat (6) @(posedge clk_sys);
        check(48'(phase_accumulator !== 48'h0), 48'h1);
        wr(8'h1f, 8'h21);
        wait_tw(low_w, 8);
        check(48'(found), 48'h1);
        // pin noise must not disturb the automatic sweep
        repeat (20) begin
            level_req = 1'($random(seed));
            repeat (6) @(posedge clk_sys);
            #1;
        end
        wait_tw(high_w, 2000);
        check(48'(found), 48'h1);
        wait_chg();
        check(48'(chg_gap), 48'h6);
        wait_tw(low_w, 2000);
        check(48'(found), 48'h1);
        results();
    end
endmodule
